// [inc/dma_hs_pkg.sv]
package dma_hs_pkg;
  // Channel count on the backplane
  localparam int NUM_CH = 2;
  localparam int DATA_W = 16;
  // Clock period in ns
  localparam int CLK_NS = 8;
  // Timing figures in ns
  localparam int T_OUT_RDY_MAX_NS = 3000;
  localparam int T_IN_RDY_MAX_NS = 2500;
  localparam int T_IN_SETUP_MIN_NS = 30;
  localparam int T_RDY_REL_MAX_NS = 50;
  localparam int T_RW_SETUP_MIN_NS = 15;
  localparam int T_REREQ_P0_MAX_NS = 65;
  localparam int T_REREQ_P1_MAX_NS = 1600;
  localparam int T_BERR_NS = 2500;
  // Derived cycle counts: least times round up, longest round down
  localparam int IN_SETUP_CYC = (T_IN_SETUP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RW_SETUP_CYC = (T_RW_SETUP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int OUT_RDY_CYC = T_OUT_RDY_MAX_NS / CLK_NS;
  localparam int IN_RDY_CYC = T_IN_RDY_MAX_NS / CLK_NS;
  localparam int REREQ_P0_CYC = T_REREQ_P0_MAX_NS / CLK_NS;
  localparam int REREQ_P1_CYC = T_REREQ_P1_MAX_NS / CLK_NS;
  localparam int BERR_CYC = T_BERR_NS / CLK_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
endpackage

// [inc/dma_hs_if.sv]
interface dma_hs_if;
  import dma_hs_pkg::*;
  logic [NUM_CH-1:0] xfer_request;
  logic [NUM_CH-1:0] xfer_acknowledge;
  logic io_side_ready_reply;
  logic bus_read_write_line;
  logic bus_address_strobe;
  logic lower_byte_strobe;
  logic upper_byte_strobe;
  logic memory_transfer_ack;
  logic last_transfer;
  logic [DATA_W-1:0] card_data;
  logic card_data_oe;
  logic [DATA_W-1:0] ctrl_data;
  logic ctrl_data_oe;
  // Active-high in logic; polarity of the physical lines is outside
  modport card
  (
    output xfer_request,
    output io_side_ready_reply,
    output card_data,
    output card_data_oe,
    input xfer_acknowledge,
    input bus_read_write_line,
    input memory_transfer_ack,
    input last_transfer,
    input ctrl_data
  );
  modport ctrl
  (
    input xfer_request,
    input io_side_ready_reply,
    input card_data,
    input card_data_oe,
    output xfer_acknowledge,
    output bus_read_write_line,
    output bus_address_strobe,
    output lower_byte_strobe,
    output upper_byte_strobe,
    output memory_transfer_ack,
    output last_transfer,
    output ctrl_data,
    output ctrl_data_oe
  );
endinterface

// [src/dma_card_end.sv]
module dma_card_end
  import dma_hs_pkg::*;
#(
  parameter int CH = 0,
  parameter bit DROP_REQ = 1'b1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Link
  dma_hs_if.card link,
  // User side
  input wire logic chan_enable_i,
  input wire logic priority_i,
  input wire logic use_last_i,
  input wire logic out_ready_i,
  input wire logic in_valid_i,
  input wire logic [DATA_W-1:0] in_data_i,
  output logic out_valid_o,
  output logic [DATA_W-1:0] out_data_o,
  output logic in_taken_o,
  output logic done_o
);
  import dma_hs_pkg::*;

  // Channel index must name one of the request lines
  if (CH < 0 || CH >= NUM_CH)
  begin : g_bad_ch
    $error("CH out of range");
  end

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_READY, S_WAIT_REL} card_state_t;
  card_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic req_r;
  logic rdy_r;
  logic stop_r;
  logic [DATA_W-1:0] dout_r;
  logic dout_oe_r;
  logic ack;
  logic is_out;
  logic have_data;
  logic last_r;

  assign ack = link.xfer_acknowledge[CH];
  // Read level means output: memory to card
  assign is_out = link.bus_read_write_line;
  assign have_data = is_out ? out_ready_i : in_valid_i;

  ////////////////////////////////////////////////////////////////
  // Request line
  // Dropping on acknowledge costs a cycle per unit but keeps this simple
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      req_r <= 1'b0;
    end
    else if (!chan_enable_i || stop_r)
    begin
      req_r <= 1'b0;
    end
    else if (ack && DROP_REQ)
    begin
      req_r <= 1'b0;
    end
    else if (!ack || link.memory_transfer_ack)
    begin
      // Re-raise on memory ack keeps the bus with priority 0
      req_r <= have_data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      stop_r <= 1'b0;
    end
    else if (!chan_enable_i)
    begin
      stop_r <= 1'b0;
    end
    // After the last unit stay quiet until re-enabled
    else if (ack && link.last_transfer && use_last_i)
    begin
      stop_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Last-unit marker
  // The controller shows it only while acknowledge stands, so it is held
  // here until the cycle is over and done can be reported
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      last_r <= 1'b0;
    end
    else if (ack)
    begin
      last_r <= link.last_transfer;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Cycle engine
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_r <= S_IDLE;
      cnt_r <= CNT_ZERO;
      rdy_r <= 1'b0;
      dout_r <= '0;
      dout_oe_r <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      in_taken_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      out_valid_o <= 1'b0;
      in_taken_o <= 1'b0;
      done_o <= 1'b0;
      case (st_r)
        S_IDLE:
        begin
          if (ack && is_out && link.memory_transfer_ack)
          begin
            // Memory ack acts as our data strobe
            out_data_o <= link.ctrl_data;
            out_valid_o <= 1'b1;
            rdy_r <= 1'b1;
            st_r <= S_WAIT_REL;
          end
          else if (ack && !is_out)
          begin
            // Data goes out at once; ready waits for setup
            dout_r <= in_data_i;
            dout_oe_r <= 1'b1;
            in_taken_o <= 1'b1;
            cnt_r <= CNT_ZERO;
            st_r <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          // Data held long enough before ready rises
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(IN_SETUP_CYC))
          begin
            rdy_r <= 1'b1;
            st_r <= S_WAIT_REL;
          end
        end
        S_WAIT_REL:
        begin
          if (!ack)
          begin
            // One cycle, well inside the release limit
            rdy_r <= 1'b0;
            dout_oe_r <= 1'b0;
            done_o <= last_r;
            st_r <= S_IDLE;
          end
        end
        default:
        begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // Only our own channel line is ever raised
  always_comb
  begin
    link.xfer_request = '0;
    link.xfer_request[CH] = req_r;
  end
  assign link.io_side_ready_reply = rdy_r;
  assign link.card_data = dout_r;
  assign link.card_data_oe = dout_oe_r;
endmodule

// [src/dma_ctrl_end.sv]
module dma_ctrl_end
  import dma_hs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Link
  dma_hs_if.ctrl link,
  // Programming
  input wire logic start_i,
  input wire logic [CNT_W-1:0] count_i,
  input wire logic output_dir_i,
  input wire logic byte_mode_i,
  input wire logic priority_i,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic bus_grant_i,
  // Status
  output logic bus_request_o,
  output logic busy_o,
  output logic bus_error_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  output logic mem_wvalid_o
);
  import dma_hs_pkg::*;

  typedef enum logic [2:0] {C_IDLE, C_ARB, C_SETUP, C_CYC, C_MEMWR, C_HOLD} ctrl_state_t;
  ctrl_state_t st_r;
  logic [CNT_W-1:0] left_r;
  logic [CNT_W-1:0] tmr_r;
  logic hi_byte_r;
  logic ack_r;
  logic as_r;
  logic lds_r;
  logic uds_r;
  logic mack_r;
  logic rw_r;
  logic [DATA_W-1:0] d_r;
  logic any_req;

  assign any_req = |link.xfer_request;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_r <= C_IDLE;
      left_r <= CNT_ZERO;
      tmr_r <= CNT_ZERO;
      hi_byte_r <= 1'b0;
      {ack_r, as_r, lds_r, uds_r, mack_r} <= 5'h00;
      rw_r <= 1'b1;
      d_r <= '0;
      bus_request_o <= 1'b0;
      busy_o <= 1'b0;
      bus_error_o <= 1'b0;
      mem_wdata_o <= '0;
      mem_wvalid_o <= 1'b0;
    end
    else
    begin
      mem_wvalid_o <= 1'b0;
      tmr_r <= tmr_r + 1'b1;
      case (st_r)
        C_IDLE:
        begin
          if (start_i)
          begin
            left_r <= count_i;
            busy_o <= count_i != CNT_ZERO;
            bus_error_o <= 1'b0;
          end
          else if (busy_o && any_req)
          begin
            bus_request_o <= 1'b1;
            st_r <= C_ARB;
          end
        end
        C_ARB:
        begin
          if (bus_grant_i)
          begin
            rw_r <= output_dir_i;
            tmr_r <= CNT_ZERO;
            st_r <= C_SETUP;
          end
        end
        C_SETUP:
        begin
          if (tmr_r == CNT_W'(RW_SETUP_CYC))
          begin
            as_r <= 1'b1;
            ack_r <= 1'b1;
            tmr_r <= CNT_ZERO;
            if (output_dir_i)
            begin
              lds_r <= !byte_mode_i || !hi_byte_r;
              uds_r <= !byte_mode_i || hi_byte_r;
            end
            st_r <= C_CYC;
          end
        end
        C_CYC:
        begin
          if (output_dir_i)
          begin
            if (mem_ack_i && !mack_r)
            begin
              mack_r <= 1'b1;
              d_r <= (byte_mode_i && hi_byte_r) ? {8'h00, mem_rdata_i[15:8]} : mem_rdata_i;
              tmr_r <= CNT_ZERO;
            end
            if (link.io_side_ready_reply)
            begin
              st_r <= C_HOLD;
            end
          end
          else if (link.io_side_ready_reply)
          begin
            lds_r <= !byte_mode_i || !hi_byte_r;
            uds_r <= !byte_mode_i || hi_byte_r;
            d_r <= (byte_mode_i && hi_byte_r) ? {link.card_data[7:0], 8'h00} : link.card_data;
            st_r <= C_MEMWR;
          end
          else if (tmr_r == CNT_W'(BERR_CYC))
          begin
            bus_error_o <= 1'b1;
            busy_o <= 1'b0;
            bus_request_o <= 1'b0;
            {ack_r, as_r, lds_r, uds_r} <= 4'h0;
            rw_r <= 1'b1;
            st_r <= C_IDLE;
          end
        end
        C_MEMWR:
        begin
          mack_r <= 1'b1;
          mem_wdata_o <= d_r;
          mem_wvalid_o <= 1'b1;
          tmr_r <= CNT_ZERO;
          st_r <= C_HOLD;
        end
        C_HOLD:
        begin
          {ack_r, as_r, lds_r, uds_r, mack_r} <= 5'h00;
          if (ack_r)
          begin
            left_r <= left_r - 1'b1;
            hi_byte_r <= byte_mode_i && !hi_byte_r;
            if (left_r == CNT_W'(1))
            begin
              busy_o <= 1'b0;
            end
          end
          if (!ack_r && (left_r == CNT_ZERO))
          begin
            bus_request_o <= 1'b0;
            rw_r <= 1'b1;
            st_r <= C_IDLE;
          end
          else if (!ack_r && any_req && !link.io_side_ready_reply)
          begin
            rw_r <= output_dir_i;
            tmr_r <= CNT_ZERO;
            st_r <= C_SETUP;
          end
          else if (!ack_r && tmr_r >= CNT_W'(priority_i ? REREQ_P1_CYC : REREQ_P0_CYC))
          begin
            bus_request_o <= 1'b0;
            rw_r <= 1'b1;
            st_r <= C_IDLE;
          end
        end
        default:
        begin
          st_r <= C_IDLE;
        end
      endcase
    end
  end

  assign link.xfer_acknowledge = {NUM_CH{ack_r}};
  assign link.bus_read_write_line = rw_r;
  assign link.bus_address_strobe = as_r;
  assign link.lower_byte_strobe = lds_r;
  assign link.upper_byte_strobe = uds_r;
  assign link.memory_transfer_ack = mack_r;
  assign link.last_transfer = ack_r && (left_r == CNT_W'(1));
  assign link.ctrl_data = d_r;
  assign link.ctrl_data_oe = output_dir_i && mack_r;
endmodule

// [tb/dma_slave_handshake_chk.sv]
module dma_slave_handshake_chk
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Link
  input wire logic [dma_hs_pkg::NUM_CH-1:0] xfer_acknowledge,
  input wire logic io_side_ready_reply,
  input wire logic bus_read_write_line,
  input wire logic bus_address_strobe,
  input wire logic lower_byte_strobe,
  input wire logic upper_byte_strobe,
  input wire logic card_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import dma_hs_pkg::*;
  localparam int OUT_MAX = OUT_RDY_CYC;
  localparam int REL_MAX = T_RDY_REL_MAX_NS / CLK_NS;
  localparam int BERR_MAX = BERR_CYC + 4;
  wire logic a = xfer_acknowledge[0];
  wire logic r = io_side_ready_reply;
  wire logic rw = bus_read_write_line;
  wire logic s = lower_byte_strobe | upper_byte_strobe;
  logic [9:0] wait_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  sequence out_go;
    $rose(a) && rw;
  endsequence
  sequence in_go;
    $rose(a) && !rw;
  endsequence
  // Input cycle length without a reply
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !a || r || rw)
      wait_r <= 10'h000;
    else
      wait_r <= wait_r + 10'h001;
  end
  ////////////////////////////////////////
  chk_ack_equal: assert property (xfer_acknowledge[1] == a)
    else $error("acknowledge lines differ");
  chk_ack_strobes: assert property ($rose(a) |-> bus_address_strobe && (rw ? s : !s))
    else $error("strobes wrong at acknowledge");
  chk_rw_setup: assert property ($rose(a) |-> $stable(rw) && rw == $past(rw, RW_SETUP_CYC))
    else $error("direction moved with acknowledge");
  chk_out_ready: assert property (out_go |-> ##[1:OUT_MAX] r)
    else $error("output ready too late");
  chk_in_early: assert property (in_go |-> !r [*4])
    else $error("input ready too early");
  chk_in_setup: assert property ($rose(r) && !rw |-> card_data_oe && $past(card_data_oe, IN_SETUP_CYC))
    else $error("input data not set up");
  chk_rdy_release: assert property ($fell(a) |-> ##[0:REL_MAX] !r)
    else $error("ready held after acknowledge");
  chk_in_strobe: assert property (!rw && s |-> r || $past(r))
    else $error("memory strobe before ready");
  chk_out_end: assert property ($fell(a) && $past(rw) |-> $past(r))
    else $error("output cycle ended without ready");
  chk_berr_abort: assert property (wait_r <= BERR_MAX)
    else $error("input cycle not aborted");
endmodule

// [tb/tb_dma_slave_handshake.sv]
module tb_dma_slave_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_hs_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic chan_enable_i = 1'b1;
  logic priority_i = 1'b0;
  logic use_last_i = 1'b1;
  logic out_ready_i = 1'b1;
  logic in_valid_i = 1'b1;
  logic [DATA_W-1:0] in_data_i = 16'h3c5a;
  logic start_i = 1'b0;
  logic start2 = 1'b0;
  logic [CNT_W-1:0] count_i = 10'h001;
  logic output_dir_i = 1'b1;
  logic byte_mode_i = 1'b0;
  logic [DATA_W-1:0] mem_rdata_i = 16'ha5c3;
  logic mem_ack_i = 1'b0;
  logic bus_grant_i = 1'b0;
  logic out_valid_o, in_taken_o, done_o, bus_request_o, busy_o, bus_error_o, mem_wvalid_o, breq2, berr2;
  logic [DATA_W-1:0] out_data_o, mem_wdata_o;
  logic [DATA_W-1:0] got_q[$];
  int n_fail = 0, n_compared = 0, n_done = 0, n_berr = 0, n_cyc = 0, n_taken = 0;
  dma_hs_if dma_hs_if_i();
  dma_hs_if dma_hs_if2();
  dma_card_end dma_card_end_i (.clk_i, .srst_i, .link(dma_hs_if_i), .chan_enable_i, .priority_i, .use_last_i,
    .out_ready_i, .in_valid_i, .in_data_i, .out_valid_o, .out_data_o, .in_taken_o, .done_o);
  dma_ctrl_end dma_ctrl_end_i (.clk_i, .srst_i, .link(dma_hs_if_i), .start_i, .count_i, .output_dir_i,
    .byte_mode_i, .priority_i, .mem_rdata_i, .mem_ack_i, .bus_grant_i, .bus_request_o, .busy_o, .bus_error_o,
    .mem_wdata_o, .mem_wvalid_o);
  // Faulty card: requests but never replies
  dma_ctrl_end dma_ctrl_end2_i (.clk_i, .srst_i, .link(dma_hs_if2), .start_i(start2), .count_i,
    .output_dir_i(1'b0), .byte_mode_i, .priority_i, .mem_rdata_i, .mem_ack_i(1'b0), .bus_grant_i(breq2),
    .bus_request_o(breq2), .busy_o(), .bus_error_o(berr2), .mem_wdata_o(), .mem_wvalid_o());
  assign dma_hs_if2.xfer_request = 2'b01;
  assign dma_hs_if2.io_side_ready_reply = 1'b0;
  assign dma_hs_if2.card_data = 16'h0000;
  assign dma_hs_if2.card_data_oe = 1'b0;
  dma_slave_handshake_chk dma_slave_handshake_chk_i (.clk_i, .srst_i,
    .xfer_acknowledge(dma_hs_if_i.xfer_acknowledge), .io_side_ready_reply(dma_hs_if_i.io_side_ready_reply),
    .bus_read_write_line(dma_hs_if_i.bus_read_write_line), .bus_address_strobe(dma_hs_if_i.bus_address_strobe),
    .lower_byte_strobe(dma_hs_if_i.lower_byte_strobe), .upper_byte_strobe(dma_hs_if_i.upper_byte_strobe),
    .card_data_oe(dma_hs_if_i.card_data_oe));
  ////////////////////////////////////////
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  // Memory answers one cycle after its strobes, holds until released
  always @(posedge clk_i)
  begin
    bus_grant_i <= bus_request_o;
    mem_ack_i <= dma_hs_if_i.lower_byte_strobe | dma_hs_if_i.upper_byte_strobe;
    n_cyc <= n_cyc + 1;
    if (out_valid_o === 1'b1)
      got_q.push_back(out_data_o);
    if (mem_wvalid_o === 1'b1)
      got_q.push_back(mem_wdata_o);
    if (done_o === 1'b1)
      n_done++;
    if (in_taken_o === 1'b1)
      n_taken++;
    if (berr2 === 1'b1)
      n_berr++;
    if (n_cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Fresh reset per run keeps runs apart
  task automatic xfer(input logic d, b, p, input logic [CNT_W-1:0] n);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    got_q.delete();
    n_done = 0;
    n_taken = 0;
    output_dir_i <= d;
    byte_mode_i <= b;
    priority_i <= p;
    count_i <= n;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 2000 && busy_o !== 1'b0; k++) @(posedge clk_i);
    // Let the last release and its pulses be counted
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_out_word();
    use_last_i <= 1'b0;
    xfer(1'b1, 1'b0, 1'b0, 10'h003);
    chk("out count", 16'h0003, 16'(got_q.size()));
    for (int k = 0; k < got_q.size(); k++)
      chk("out word", 16'ha5c3, got_q[k]);
    chk("done", 16'h0001, 16'(n_done));
    chk("bus released", 16'h0000, {15'h0000, bus_request_o});
    use_last_i <= 1'b1;
  endtask
  task automatic t_out_byte();
    xfer(1'b1, 1'b1, 1'b1, 10'h002);
    chk("out count", 16'h0002, 16'(got_q.size()));
    chk("low byte", 16'h00c3, {8'h00, got_q[0][7:0]});
    chk("folded byte", 16'h00a5, {8'h00, got_q[1][7:0]});
  endtask
  task automatic t_in_byte();
    xfer(1'b0, 1'b1, 1'b0, 10'h002);
    chk("in count", 16'h0002, 16'(got_q.size()));
    chk("low lane", 16'h005a, {8'h00, got_q[0][7:0]});
    chk("high lane", 16'h005a, {8'h00, got_q[1][15:8]});
    chk("in taken", 16'h0002, 16'(n_taken));
  endtask
  task automatic t_in_word();
    xfer(1'b0, 1'b0, 1'b1, 10'h001);
    chk("in count", 16'h0001, 16'(got_q.size()));
    chk("in word", 16'h3c5a, got_q[0]);
    chk("in taken", 16'h0001, 16'(n_taken));
    chk("no bus error", 16'h0000, {15'h0000, bus_error_o});
  endtask
  task automatic t_disabled();
    chan_enable_i <= 1'b0;
    xfer(1'b1, 1'b0, 1'b0, 10'h001);
    chk("disabled count", 16'h0000, 16'(got_q.size()));
    chan_enable_i <= 1'b1;
  endtask
  task automatic t_berr();
    @(posedge clk_i);
    start2 <= 1'b1;
    n_berr = 0;
    @(posedge clk_i);
    start2 <= 1'b0;
    repeat (BERR_CYC - 10) @(posedge clk_i);
    chk("early error", 16'h0000, 16'(n_berr));
    repeat (30) @(posedge clk_i);
    chk("bus error", 16'h0001, 16'(n_berr != 0));
    chk("bus dropped", 16'h0000, {15'h0000, breq2});
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    t_out_word();
    t_out_byte();
    t_in_byte();
    t_in_word();
    t_disabled();
    t_berr();
    give_verdict();
  end
endmodule
